/* shared/scs_pkg.sv */
// constants, types and carriers of the segment and control state block
//
// Summary of operation
// - six 16-bit selector registers name the currently addressable segments
// - protected mode segments may span one byte up to the full 4 Gbytes
// - real mode segment size is fixed at 64 Kbytes whatever the selector
// - accesses wrapping a maximum-limit segment raise a limit violation
// - code selector serves fetches, stack selector stacks, four others data
// - each selector has a hidden descriptor: 32-bit base, limit, attributes
// - real mode selector load sets only base, selector shifted left four
// - protected mode selector load refreshes base, limit, attributes
// - each reference adds base, checks limit; protected mode also checks attributes against type
// - low-half load and store touch only the low 16 control bits
// - control bit 31 turns the paging unit on and off
// - task switch sets task-swapped flag; then non-wait coprocessor opcodes trap
// - bit 2 makes non-wait coprocessor opcodes fault; clear after reset
// - wait opcode traps only when monitor bit and task-swapped are set
// - control bit 0 selects protected mode; cleared returns to real mode
// - protection bit set by either load, cleared only by full load
// - fault address register captures the last page fault linear address
// - table root keeps page-aligned base; low twelve bits ignored
// - explicit root write or root-changing task switch flushes page cache
// - task switch keeping the root value does not flush the page cache
package scs_pkg;

	// =====================================================================
	// register selection for load and store
	typedef enum logic [3:0] {
		SCS_SEL_CODE   = 4'h0,
		SCS_SEL_STACK  = 4'h1,
		SCS_SEL_DATA   = 4'h2,
		SCS_SEL_EXTRA  = 4'h3,
		SCS_SEL_THIRD  = 4'h4,
		SCS_SEL_FOURTH = 4'h5,
		SCS_SEL_MCW    = 4'h6,
		SCS_SEL_FAULT  = 4'h7,
		SCS_SEL_ROOT   = 4'h8
	} scs_reg_sel_t;

	// =====================================================================
	// memory reference kinds
	typedef enum logic [1:0] {
		SCS_KIND_FETCH = 2'h0,
		SCS_KIND_STACK = 2'h1,
		SCS_KIND_DATA  = 2'h2
	} scs_mem_kind_t;

	// =====================================================================
	// descriptor and reference carriers
	typedef struct packed {
		logic present;
		logic code;
		logic rw;
	} scs_attr_t;

	typedef struct packed {
		logic [31:0] base;
		logic [31:0] limit;
		scs_attr_t   attr;
	} scs_desc_t;

	typedef struct packed {
		scs_mem_kind_t kind;
		logic [1:0]    dseg;
		logic [31:0]   offset;
		logic          write;
		logic [1:0]    size_m1;
	} scs_mem_req_t;

	typedef struct packed {
		logic [31:0] lin_addr;
		logic        limit_fault;
		logic        type_fault;
	} scs_mem_rsp_t;

	// =====================================================================
	// positions, masks and reset values
	localparam int          SCS_NUM_SEGS   = 6;
	localparam int          SCS_LOW_W      = 16;
	localparam int          SCS_MCW_PG     = 31;
	localparam int          SCS_MCW_RSV    = 4;
	localparam int          SCS_MCW_TS     = 3;
	localparam int          SCS_MCW_EM     = 2;
	localparam int          SCS_MCW_MP     = 1;
	localparam int          SCS_MCW_PE     = 0;
	localparam int          SCS_REAL_SHIFT = 4;
	localparam logic [31:0] SCS_MCW_IMPL   = 32'h8000_001F;
	localparam logic [31:0] SCS_MCW_RESET  = 32'h0000_0000;
	localparam logic [31:0] SCS_REAL_LIMIT = 32'h0000_FFFF;
	localparam logic [31:0] SCS_ROOT_MASK  = 32'hFFFF_F000;
	localparam logic [31:0] SCS_ROOT_RESET = 32'h0000_0000;
	localparam logic [31:0] SCS_FAULT_RST  = 32'h0000_0000;
	localparam logic [15:0] SCS_SEG_RESET  = 16'h0000;
	localparam scs_attr_t   SCS_REAL_ATTR  = '{present: 1'b1,
	                                           code: 1'b0, rw: 1'b1};
	localparam scs_desc_t   SCS_DESC_RESET = '{base: 32'h0000_0000,
	                                           limit: 32'h0000_FFFF,
	                                           attr: SCS_REAL_ATTR};

endpackage

/* src/scs_segctl.sv */
// segment selectors, hidden descriptors and machine control registers
`timescale 1ns/1ps
`default_nettype none
module scs_segctl (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 clk_en,
	input  wire logic                 wr_valid,
	input  wire scs_pkg::scs_reg_sel_t wr_sel,
	input  wire logic                 wr_low,
	input  wire logic [31:0]          wr_data,
	input  wire scs_pkg::scs_desc_t   wr_desc,
	input  wire logic                 rd_valid,
	input  wire scs_pkg::scs_reg_sel_t rd_sel,
	input  wire logic                 rd_low,
	output logic [31:0]               rd_data,
	output logic                      rd_ack,
	input  wire logic                 task_switch,
	input  wire logic [31:0]          task_root,
	input  wire logic                 pf_valid,
	input  wire logic [31:0]          pf_addr,
	input  wire logic                 mem_valid,
	input  wire scs_pkg::scs_mem_req_t mem_req,
	output logic                      mem_ack,
	output scs_pkg::scs_mem_rsp_t     mem_rsp,
	input  wire logic                 cop_valid,
	input  wire logic                 cop_is_wait,
	output logic                      cop_ack,
	output logic                      cop_trap,
	output logic                      prot_mode,
	output logic                      paging_en,
	output logic [31:0]               table_root,
	output logic                      tlb_flush
);

	// =====================================================================
	// decode helpers
	function automatic logic is_seg(scs_pkg::scs_reg_sel_t s);
		is_seg = (s <= scs_pkg::SCS_SEL_FOURTH);
	endfunction

	// selector used by a reference kind
	function automatic logic [2:0] seg_for(scs_pkg::scs_mem_kind_t k,
	                                       logic [1:0] d);
		if (k == scs_pkg::SCS_KIND_FETCH) begin
			seg_for = 3'h0;
		end else if (k == scs_pkg::SCS_KIND_STACK) begin
			seg_for = 3'h1;
		end else begin
			seg_for = 3'(d) + 3'h2;
		end
	endfunction

	logic        seg_wr;
	logic        mcw_wr;
	logic        fault_wr;
	logic        root_wr;
	logic [2:0]  wr_idx;

	// write strobes per register
	assign seg_wr   = wr_valid && is_seg(wr_sel);
	assign mcw_wr   = wr_valid && (wr_sel == scs_pkg::SCS_SEL_MCW);
	assign fault_wr = wr_valid && (wr_sel == scs_pkg::SCS_SEL_FAULT);
	assign root_wr  = wr_valid && (wr_sel == scs_pkg::SCS_SEL_ROOT);
	assign wr_idx   = wr_sel[2:0];

	// =====================================================================
	// machine control word
	logic [31:0] mcw_q;
	logic [31:0] mcw_d;

	// next control word value
	always_comb begin
		mcw_d = mcw_q;
		if (mcw_wr) begin
			if (wr_low) begin
				mcw_d[scs_pkg::SCS_LOW_W-1:0] = wr_data[15:0] &
					scs_pkg::SCS_MCW_IMPL[15:0];
				mcw_d[scs_pkg::SCS_MCW_PE] = mcw_q[scs_pkg::SCS_MCW_PE] |
					wr_data[scs_pkg::SCS_MCW_PE];
			end else begin
				mcw_d = wr_data & scs_pkg::SCS_MCW_IMPL;
			end
		end
		if (task_switch) begin
			mcw_d[scs_pkg::SCS_MCW_TS] = 1'b1;
		end
	end

	// control word register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mcw_q <= scs_pkg::SCS_MCW_RESET;
		end else if (clk_en) begin
			mcw_q <= mcw_d;
		end
	end

	assign prot_mode = mcw_q[scs_pkg::SCS_MCW_PE];
	assign paging_en = mcw_q[scs_pkg::SCS_MCW_PG];

	// =====================================================================
	// selectors and hidden descriptors
	logic [15:0]        seg_q  [scs_pkg::SCS_NUM_SEGS];
	logic [15:0]        seg_d  [scs_pkg::SCS_NUM_SEGS];
	scs_pkg::scs_desc_t desc_q [scs_pkg::SCS_NUM_SEGS];
	scs_pkg::scs_desc_t desc_d [scs_pkg::SCS_NUM_SEGS];

	for (genvar i = 0; i < scs_pkg::SCS_NUM_SEGS; i++) begin : g_seg
		// selector load updates its descriptor by mode
		always_comb begin
			seg_d[i]  = seg_q[i];
			desc_d[i] = desc_q[i];
			if (seg_wr && (wr_idx == 3'(i))) begin
				seg_d[i] = wr_data[15:0];
				if (prot_mode) begin
					desc_d[i] = wr_desc;
				end else begin
					desc_d[i].base = 32'(wr_data[15:0]) <<
						scs_pkg::SCS_REAL_SHIFT;
				end
			end
		end

		// selector and descriptor registers
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				seg_q[i]  <= scs_pkg::SCS_SEG_RESET;
				desc_q[i] <= scs_pkg::SCS_DESC_RESET;
			end else if (clk_en) begin
				seg_q[i]  <= seg_d[i];
				desc_q[i] <= desc_d[i];
			end
		end
	end

	// =====================================================================
	// fault address and table root
	logic [31:0] fault_q;
	logic [31:0] fault_d;
	logic [31:0] root_q;
	logic [31:0] root_d;
	logic        flush_q;
	logic        flush_d;
	logic [31:0] task_root_m;

	assign task_root_m = task_root & scs_pkg::SCS_ROOT_MASK;

	// next fault address, root and flush pulse
	always_comb begin
		fault_d = fault_q;
		if (fault_wr) begin
			fault_d = wr_data;
		end
		if (pf_valid) begin
			fault_d = pf_addr;
		end
		root_d  = root_q;
		flush_d = 1'b0;
		if (task_switch && (task_root_m != root_q)) begin
			root_d  = task_root_m;
			flush_d = 1'b1;
		end
		if (root_wr) begin
			root_d  = wr_data & scs_pkg::SCS_ROOT_MASK;
			flush_d = 1'b1;
		end
	end

	// fault, root and flush registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_q <= scs_pkg::SCS_FAULT_RST;
			root_q  <= scs_pkg::SCS_ROOT_RESET;
			flush_q <= 1'b0;
		end else if (clk_en) begin
			fault_q <= fault_d;
			root_q  <= root_d;
			flush_q <= flush_d;
		end
	end

	assign table_root = root_q;
	assign tlb_flush  = flush_q;

	// =====================================================================
	// memory reference: base add, limit and type checks
	logic [2:0]            ref_idx;
	scs_pkg::scs_desc_t    ref_desc;
	logic [32:0]           ref_end;
	logic [31:0]           ref_lim;
	logic                  is_fetch;
	logic                  ref_tflt;
	scs_pkg::scs_mem_rsp_t rsp_q;
	scs_pkg::scs_mem_rsp_t rsp_d;
	logic                  mack_q;

	assign ref_idx  = seg_for(mem_req.kind, mem_req.dseg);
	assign ref_desc = desc_q[ref_idx];
	assign ref_end  = {1'b0, mem_req.offset} + 33'(mem_req.size_m1);
	assign is_fetch = (mem_req.kind == scs_pkg::SCS_KIND_FETCH);

	// limit per mode and attribute check
	always_comb begin
		ref_lim  = prot_mode ? ref_desc.limit :
			scs_pkg::SCS_REAL_LIMIT;
		ref_tflt = 1'b0;
		if (prot_mode) begin
			ref_tflt = !ref_desc.attr.present ||
				(is_fetch && !ref_desc.attr.code) ||
				(mem_req.write && (ref_desc.attr.code ||
					!ref_desc.attr.rw)) ||
				(!is_fetch && !mem_req.write &&
					ref_desc.attr.code && !ref_desc.attr.rw);
		end
		rsp_d             = rsp_q;
		if (mem_valid) begin
			rsp_d.lin_addr    = ref_desc.base + mem_req.offset;
			rsp_d.limit_fault = ref_end > {1'b0, ref_lim};
			rsp_d.type_fault  = ref_tflt;
		end
	end

	// reference answer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_q  <= '0;
			mack_q <= 1'b0;
		end else if (clk_en) begin
			rsp_q  <= rsp_d;
			mack_q <= mem_valid;
		end
	end

	assign mem_rsp = rsp_q;
	assign mem_ack = mack_q;

	// =====================================================================
	// coprocessor opcode traps
	logic cop_trap_q;
	logic cop_trap_d;
	logic cop_ack_q;

	// trap decision from control bits
	always_comb begin
		cop_trap_d = cop_trap_q;
		if (cop_valid) begin
			if (cop_is_wait) begin
				cop_trap_d = mcw_q[scs_pkg::SCS_MCW_MP] &&
					mcw_q[scs_pkg::SCS_MCW_TS];
			end else begin
				cop_trap_d = mcw_q[scs_pkg::SCS_MCW_EM] ||
					mcw_q[scs_pkg::SCS_MCW_TS];
			end
		end
	end

	// trap answer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cop_trap_q <= 1'b0;
			cop_ack_q  <= 1'b0;
		end else if (clk_en) begin
			cop_trap_q <= cop_trap_d;
			cop_ack_q  <= cop_valid;
		end
	end

	assign cop_trap = cop_trap_q;
	assign cop_ack  = cop_ack_q;

	// =====================================================================
	// store path
	logic [31:0] rd_q;
	logic [31:0] rd_d;
	logic        rack_q;

	// read mux, low-half store masks the upper bits
	always_comb begin
		rd_d = rd_q;
		if (rd_valid) begin
			if (is_seg(rd_sel)) begin
				rd_d = {16'h0000, seg_q[rd_sel[2:0]]};
			end else if (rd_sel == scs_pkg::SCS_SEL_MCW) begin
				rd_d = rd_low ? {16'h0000, mcw_q[15:0]} :
					mcw_q;
			end else if (rd_sel == scs_pkg::SCS_SEL_FAULT) begin
				rd_d = fault_q;
			end else if (rd_sel == scs_pkg::SCS_SEL_ROOT) begin
				rd_d = root_q;
			end else begin
				rd_d = 32'h0000_0000;
			end
		end
	end

	// read data registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_q   <= 32'h0000_0000;
			rack_q <= 1'b0;
		end else if (clk_en) begin
			rd_q   <= rd_d;
			rack_q <= rd_valid;
		end
	end

	assign rd_data = rd_q;
	assign rd_ack  = rack_q;

	// =====================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_low_write;
		clk_en && mcw_wr && wr_low;
	endsequence

	sequence s_root_kept;
		clk_en && task_switch && !root_wr && (task_root_m == root_q);
	endsequence

	a_pe_low_keep: assert property (
		s_low_write and prot_mode |=> prot_mode)
		else $error("low-half load cleared protection");

	a_low_upper_hold: assert property (
		s_low_write |=> mcw_q[31:16] == $past(mcw_q[31:16]))
		else $error("low-half load changed upper bits");

	a_ts_on_switch: assert property (
		clk_en && task_switch |=> mcw_q[scs_pkg::SCS_MCW_TS])
		else $error("task switch did not set swapped flag");

	a_root_flush_wr: assert property (
		clk_en && root_wr |=> tlb_flush ##1 (!tlb_flush || $past(clk_en)))
		else $error("root write did not flush");

	a_root_no_flush: assert property (
		s_root_kept |=> !tlb_flush && $stable(root_q))
		else $error("unchanged root flushed cache");

	a_prot_desc_load: assert property (
		clk_en && seg_wr && prot_mode |=>
			desc_q[$past(wr_idx)] == $past(wr_desc))
		else $error("protected load did not refresh descriptor");

	a_real_base_load: assert property (
		clk_en && seg_wr && !prot_mode |=>
			desc_q[$past(wr_idx)].base ==
			{12'h000, $past(wr_data[15:0]), 4'h0})
		else $error("real mode base not shifted selector");

	a_real_limit: assert property (
		clk_en && mem_valid && !prot_mode &&
		(mem_req.offset > scs_pkg::SCS_REAL_LIMIT) |=>
			mem_ack && mem_rsp.limit_fault)
		else $error("real mode limit not enforced");

	a_wrap_fault: assert property (
		clk_en && mem_valid && ref_end[32] |=> mem_rsp.limit_fault)
		else $error("wrap past top not flagged");

	a_wait_trap: assert property (
		clk_en && cop_valid && cop_is_wait |=>
			cop_trap == $past(mcw_q[1] && mcw_q[3]))
		else $error("wait trap decision wrong");

	a_em_trap: assert property (
		clk_en && cop_valid && !cop_is_wait &&
		mcw_q[scs_pkg::SCS_MCW_EM] |=> cop_ack && cop_trap)
		else $error("emulate bit did not fault");

	a_pf_capture: assert property (
		clk_en && pf_valid |=> fault_q == $past(pf_addr))
		else $error("page fault address not captured");

endmodule // scs_segctl
`default_nettype wire

/* testbench/scs_segctl_test.sv */
// self-checking bench of the segment and control state block
`timescale 1ns/1ps
`default_nettype none
module scs_segctl_test;
	// =================================================================
	// design connections and model state
	logic                  clk, rst, clk_en, wr_valid, wr_low, rd_valid;
	logic                  rd_low, rd_ack, task_switch, pf_valid, mem_valid;
	logic                  mem_ack, cop_valid, cop_is_wait, cop_ack;
	logic                  cop_trap, prot_mode, paging_en, tlb_flush;
	logic [31:0]           wr_data, rd_data, task_root, pf_addr, table_root;
	scs_pkg::scs_reg_sel_t wr_sel, rd_sel;
	scs_pkg::scs_desc_t    wr_desc;
	scs_pkg::scs_mem_req_t mem_req;
	scs_pkg::scs_mem_rsp_t mem_rsp;
	int unsigned           m_sel[6], m_base[6], m_lim[6], m_attr[6];
	int unsigned           m_mcw, m_fault, m_root, v;
	int                    fails, cmp_count, cyc;

	// =================================================================
	// device under test
	scs_segctl u_dut (
		.clk, .rst, .clk_en, .wr_valid, .wr_sel, .wr_low, .wr_data,
		.wr_desc, .rd_valid, .rd_sel, .rd_low, .rd_data, .rd_ack,
		.task_switch, .task_root, .pf_valid, .pf_addr, .mem_valid,
		.mem_req, .mem_ack, .mem_rsp, .cop_valid, .cop_is_wait,
		.cop_ack, .cop_trap, .prot_mode, .paging_en, .table_root,
		.tlb_flush
	);

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// cycle ceiling against a hung run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			$display("ERROR %0t timeout", $time);
			wrap_up;
		end
	end

	// =================================================================
	// compares and closing
	task automatic chk_word(logic [31:0] got, int unsigned exp, string w);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask

	task automatic chk_rsp(scs_pkg::scs_mem_rsp_t got,
		scs_pkg::scs_mem_rsp_t exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t mem got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_state;
		chk_word(prot_mode, m_mcw[0], "pe");
		chk_word(paging_en, m_mcw[31], "pg");
		chk_word(table_root, m_root, "root");
	endtask

	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// =================================================================
	// request tasks; wr, tsw and pfault update the model
	task automatic tick;
		@(posedge clk);
		#1;
	endtask

	function automatic scs_pkg::scs_desc_t rdesc();
		rdesc.base = $urandom;
		rdesc.limit = $urandom >> $urandom_range(31, 0);
		rdesc.attr = 3'($urandom_range(7, 1));
	endfunction

	task automatic wr(int s, bit low, int unsigned d,
		scs_pkg::scs_desc_t dsc);
		bit fl;
		fl = (s == 8);
		if (s == 0 && dsc.attr.code)
			dsc.attr.rw = 1'h1;
		wr_sel = scs_pkg::scs_reg_sel_t'(s[3:0]);
		wr_low = low;
		wr_data = d;
		wr_desc = dsc;
		wr_valid = 1'h1;
		tick;
		wr_valid = 1'h0;
		if (s < 6) begin
			m_sel[s] = d & 32'h0000_FFFF;
			m_base[s] = m_mcw[0] ? dsc.base : m_sel[s] << 4;
			if (m_mcw[0]) begin
				m_lim[s] = dsc.limit;
				m_attr[s] = dsc.attr;
			end
		end
		else if (s == 6 && low)
			m_mcw = (m_mcw & 32'hFFFF_FFE1) | (d & 32'h0000_001F);
		else if (s == 6)
			m_mcw = d & 32'h8000_001F;
		else if (s == 7)
			m_fault = d;
		else if (s == 8)
			m_root = d & 32'hFFFF_F000;
		chk_word(tlb_flush, fl, "flush");
		chk_state;
		tick;
		chk_word(tlb_flush, 1'h0, "pulse");
	endtask

	task automatic rd(int s, bit low);
		int unsigned e;
		e = 0;
		if (s < 6)
			e = m_sel[s];
		else if (s == 6)
			e = low ? m_mcw & 32'h0000_FFFF : m_mcw;
		else if (s == 7)
			e = m_fault;
		else if (s == 8)
			e = m_root;
		rd_sel = scs_pkg::scs_reg_sel_t'(s[3:0]);
		rd_low = low;
		rd_valid = 1'h1;
		tick;
		rd_valid = 1'h0;
		chk_word(rd_ack, 1'h1, "ack");
		chk_word(rd_data, e, "read");
		tick;
	endtask

	task automatic mref(int k, int dg, int unsigned off, bit w, int sz);
		scs_pkg::scs_mem_rsp_t e;
		logic [2:0]            a;
		int                    i;
		i = (k == 2) ? 2 + dg[1:0] : k;
		w = w & (k != 0);
		a = m_attr[i][2:0];
		e.lin_addr = m_base[i] + off;
		e.limit_fault = longint'(off) + sz[1:0] >
			(m_mcw[0] ? m_lim[i] : 32'h0000_FFFF);
		e.type_fault = m_mcw[0] & (!a[2] | (k == 0 & !a[1]) |
			(w & (a[1] | !a[0])) | (!w & k != 0 & a[1] & !a[0]));
		mem_req = '{kind: scs_pkg::scs_mem_kind_t'(k[1:0]),
			dseg: dg[1:0], offset: off, write: w, size_m1: sz[1:0]};
		mem_valid = 1'h1;
		tick;
		mem_valid = 1'h0;
		chk_word(mem_ack, 1'h1, "mack");
		chk_rsp(mem_rsp, e);
		tick;
	endtask

	task automatic cop(bit wt);
		cop_is_wait = wt;
		cop_valid = 1'h1;
		tick;
		cop_valid = 1'h0;
		chk_word(cop_ack, 1'h1, "cack");
		chk_word(cop_trap, wt ? m_mcw[1] & m_mcw[3] :
			m_mcw[2] | m_mcw[3], "trap");
		tick;
	endtask

	task automatic tsw(int unsigned r);
		bit fl;
		fl = (r & 32'hFFFF_F000) != m_root;
		task_root = r;
		task_switch = 1'h1;
		tick;
		task_switch = 0;
		m_root = r & 32'hFFFF_F000;
		m_mcw = m_mcw | 32'h0000_0008;
		chk_word(tlb_flush, fl, "tflush");
		chk_state;
		tick;
	endtask

	task automatic pfault(int unsigned a);
		pf_addr = a;
		pf_valid = 1'h1;
		tick;
		pf_valid = 1'h0;
		m_fault = a;
		rd(7, 1'h0);
	endtask

	// =================================================================
	// main sequence
	initial begin
		{clk, wr_valid, wr_low, rd_valid, rd_low, task_switch} = '0;
		{pf_valid, mem_valid, cop_valid, cop_is_wait, wr_data} = '0;
		{task_root, pf_addr, fails, cmp_count, cyc} = '0;
		{m_mcw, m_fault, m_root} = '0;
		m_sel = '{default: 0};
		m_base = '{default: 0};
		m_lim = '{default: 32'h0000_FFFF};
		m_attr = '{default: 3'h5};
		wr_sel = scs_pkg::SCS_SEL_CODE;
		rd_sel = scs_pkg::SCS_SEL_CODE;
		wr_desc = '0;
		mem_req = '0;
		rst = 1'h1;
		clk_en = 1'h1;
		repeat (6) @(posedge clk);
		#1 rst = 1'h0;
		void'($urandom(32'hd746_fb25));
		tick;
		// reset values, unmapped select included
		for (int s = 0; s < 10; s++)
			rd(s, 1'h0);
		chk_state;
		// real mode load shifts the selector into the base
		wr(2, 1'h0, 32'h1234_ABCD, rdesc());
		mref(2, 0, 32'h0000_0010, 1'h0, 0);
		// protection set by low half, kept by low half, cleared by full
		wr(6, 1'h1, 32'h0000_0001, '0);
		wr(6, 1'h1, 32'h0000_0000, '0);
		wr(6, 1'h0, m_mcw & 32'h0000_0010, '0);
		// protected loads fill whole descriptors, each kind uses its own
		wr(6, 1'h0, 32'h0000_0001, '0);
		for (int s = 0; s < 6; s++)
			wr(s, 1'h0, $urandom, rdesc());
		for (int k = 0; k < 6; k++)
			mref(k < 2 ? k : 2, k - 2, $urandom_range(255, 0),
				k[0], $urandom_range(3, 0));
		// maximum limit segment and its wrap
		wr(3, 1'h0, 32'h0000_0018,
			{32'h0000_0100, 32'hFFFF_FFFF, 3'h5});
		mref(2, 1, 32'hFFFF_FFFC, 1'h0, 3);
		mref(2, 1, 32'hFFFF_FFFE, 1'h0, 3);
		// back in real mode the limit is fixed
		wr(6, 1'h0, 32'h0000_0000, '0);
		mref(2, 1, 32'h0000_FFFF, 1'h0, 0);
		mref(2, 1, 32'h0000_FFFF, 1'h0, 1);
		// low half leaves the upper bits alone
		wr(6, 1'h0, 32'h8000_0000, '0);
		wr(6, 1'h1, 32'hFFFF_FFEE, '0);
		rd(6, 1'h1);
		// every coprocessor control combination
		for (int i = 0; i < 8; i++) begin
			wr(6, 1'h0, i << 1, '0);
			cop(1'h0);
			cop(1'h1);
		end
		wr(6, 1'h0, 32'h0000_0002, '0);
		tsw(m_root | 32'h0000_05A5);
		cop(1'h1);
		// root writes always flush, so does a switch to a changed root
		wr(8, 1'h0, 32'hABCD_E123, '0);
		wr(8, 1'h0, 32'hABCD_E000, '0);
		tsw(m_root ^ 32'h0001_0000);
		// software load of the fault register, then a fault that wins
		wr(7, 1'h0, 32'h1357_2468, '0);
		rd(7, 1'h0);
		pf_addr = 32'h0BAD_F00D;
		pf_valid = 1'h1;
		wr(7, 1'h0, 32'h2468_1357, '0);
		pf_valid = 1'h0;
		m_fault = 32'h0BAD_F00D;
		rd(7, 1'h0);
		pfault(32'hDEAD_0F0F);
		// a frozen clock enable takes no request
		clk_en = 1'h0;
		wr_sel = scs_pkg::SCS_SEL_MCW;
		wr_data = 32'h8000_0001;
		wr_valid = 1'h1;
		tick;
		wr_valid = 1'h0;
		clk_en = 1'h1;
		tick;
		chk_state;
		// random mix of all operations except fault register loads
		for (int n = 0; n < 400; n++) begin
			v = $urandom;
			case ($urandom_range(6, 0))
				0: wr($urandom_range(5, 0), 1'h0, v, rdesc());
				1: wr(6, v[20], (v & 32'hFFFF_FFEF) |
					(m_mcw & 32'h0000_0010), '0);
				2: wr(8, 1'h0, v, '0);
				3: tsw(v[0] ? m_root | v[11:0] : v);
				4: pfault(v);
				5: mref($urandom_range(2, 0), v[1:0], v >> v[4:0],
					v[5], v[7:6]);
				default: cop(v[0]);
			endcase
			rd($urandom_range(9, 0), v[8]);
		end
		wrap_up;
	end
endmodule // scs_segctl_test
`default_nettype wire
